// ---- rtl/crs_top.sv ----
// APB slave with one common synchronizer toward the core clock domain
// assumes an APB master on MCLK; CORE_CLOCK_GENERATOR is asynchronous
//
// Overview of operation
// - one shared synchronizer, one transfer at once
// - bus registers immediate, core writes synchronized
// - synchronize even with identical clocks
// - core write raises pending until done
// - stall core writes and busy-register reads
// - static core and bus registers read freely
// - read-synced read stalls, pending stays low
// - read during pending stalls twice
// - poll pending or just issue next access
// - single trigger reads selected register once
// - continuous select keeps resynchronizing register
// - pending only for first continuous transfer
// - other synchronization cancels continuous reading
// - continuous reading pauses without core clock
// - enable write syncs, reads back immediately
// - no ready flag for enable completion
// - enable sync stalls writes and synced reads
// - bus registers readable during enable sync
// - transfer lasts a fixed count of core edges
// - soft reset syncs, self-clears when done
`timescale 1ns/1ps
`default_nettype none
module crs_top
   import crs_pkg::*;
(
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic CORE_CLOCK_GENERATOR,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic DOMAIN_TRANSFER_PENDING
);
   crs_xfer_if x();

   crs_sync_engine #(
      .TICKS(SYNC_TICKS)
   ) u_eng (
      .clk(MCLK),
      .rst_n(NRST),
      .x(x)
   );

   logic [2:0] csync;
   logic clev;
   logic tick_q;
   crs_reg_t rsel;
   logic access;
   logic xfer_end;
   logic eng_busy;
   logic ctl_pend;
   logic wr_sync;
   logic capok;
   logic ok;
   logic ok_q;
   logic pend;
   crs_kind_t kind;
   crs_state_t st;
   crs_state_t next_st;
   logic next_start;
   crs_op_t next_op;
   logic [7:0] next_addr;
   logic [31:0] next_wdata;
   logic set_pend;
   crs_kind_t next_kind;
   logic direct_go;
   logic cont_go;
   logic start_q;
   crs_op_t op_q;
   logic [7:0] addr_q;
   logic [31:0] wdata_q;
   logic cont_on;
   logic [7:0] rr_addr;
   logic [31:0] cap;
   logic cap_valid;
   logic [31:0] rd_hold;
   logic en_sh;
   logic soft_reset_trigger_bit;
   logic [31:0] corea_sh;
   logic [31:0] buscfg;
   logic sync_rdy;
   logic rst_done;
   logic [31:0] rmux;

   // core clock is sampled like any pin; a level counts once stages agree
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         csync <= 3'h0;
         clev <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         csync <= {csync[1:0], CORE_CLOCK_GENERATOR};
         if (csync[1] == csync[2]) begin
            clev <= csync[2];
         end
         tick_q <= (csync[1] == csync[2]) && csync[2] && !clev;
      end
   end

   assign x.tick = tick_q;
   assign x.start = start_q;
   assign x.op = op_q;
   assign x.addr = addr_q;
   assign x.wdata = wdata_q;

   assign rsel = crs_decode(PADDR);
   assign access = PSEL && PENABLE;
   assign xfer_end = access && PREADY;
   assign eng_busy = x.busy || start_q;
   assign ctl_pend = pend && (kind == K_CTL);
   assign rst_done = x.done && (op_q == OP_RST);
   assign capok = cap_valid && (rr_addr == OFF_COUNT);
   assign wr_sync = PWRITE && ((rsel == R_CTRL) || (rsel == R_COREA) ||
      ((rsel == R_CORE_READ_REQUEST_CONTROL) && (PWDATA[RR_TRIG] || PWDATA[RR_CONT])));

   always_comb begin
      ok = 1'b1;
      if (PWRITE) begin
         if (wr_sync) begin
            ok = !eng_busy;
         end else begin
            ok = !ctl_pend;
         end
      end else begin
         case (rsel)
            R_COREA: ok = !(pend && kind == K_WR);
            R_COUNT: ok = capok || (st == S_RDONE);
            default: ok = 1'b1;
         endcase
      end
   end

   // read data is taken into PRDATA one cycle before ready is given
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         ok_q <= 1'b0;
      end else begin
         ok_q <= PSEL && ok;
      end
   end

   assign PREADY = access && ok && (PWRITE || ok_q);
   assign PSLVERR = xfer_end && (rsel == R_NONE);

   always_comb begin
      case (rsel)
         R_CTRL: rmux = {30'h0000_0000, en_sh, soft_reset_trigger_bit};
         R_STATUS: rmux = {29'h0000_0000, cont_on, sync_rdy, pend};
         R_CORE_READ_REQUEST_CONTROL: rmux = {16'h0000, 1'b0, cont_on, 6'h00, rr_addr};
         R_BUSCFG: rmux = buscfg;
         R_COREA: rmux = corea_sh;
         R_COUNT: rmux = (st == S_RDONE) ? rd_hold : cap;
         default: rmux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         PRDATA <= 32'h0000_0000;
      end else if (PSEL && !PWRITE) begin
         PRDATA <= rmux;
      end
   end

   // who gets the synchronizer next: a finished write, then a stalled
   // read, and a continuous repeat only while the bus is quiet
   always_comb begin
      next_start = 1'b0;
      next_op = OP_RD;
      next_addr = 8'h00;
      next_wdata = PWDATA;
      set_pend = 1'b0;
      next_kind = K_RD;
      direct_go = 1'b0;
      cont_go = 1'b0;
      if (xfer_end && wr_sync) begin
         next_start = 1'b1;
         set_pend = 1'b1;
         unique case (rsel)
            R_CTRL: begin
               next_op = PWDATA[CTRL_SOFT_RESET_TRIGGER] ? OP_RST : OP_EN;
               next_kind = K_CTL;
            end
            R_COREA: begin
               next_op = OP_WR;
               next_kind = K_WR;
            end
            default: begin
               next_addr = PWDATA[7:0];
            end
         endcase
      end else if (st == S_IDLE && PSEL && !PWRITE && rsel == R_COUNT &&
                   !capok && !eng_busy) begin
         next_start = 1'b1;
         next_addr = OFF_COUNT;
         direct_go = 1'b1;
      end else if (cont_on && !eng_busy && !PSEL) begin
         next_start = 1'b1;
         next_addr = rr_addr;
         cont_go = 1'b1;
      end
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         start_q <= 1'b0;
         op_q <= OP_RD;
         addr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
      end else begin
         start_q <= next_start;
         if (next_start) begin
            op_q <= next_op;
            addr_q <= next_addr;
            wdata_q <= next_wdata;
         end
      end
   end

   // a new start wins over the completion of the previous transfer
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         pend <= 1'b0;
         kind <= K_RD;
      end else if (set_pend) begin
         pend <= 1'b1;
         kind <= next_kind;
      end else if (x.done) begin
         pend <= 1'b0;
      end
   end

   assign DOMAIN_TRANSFER_PENDING = pend;

   always_comb begin
      next_st = st;
      unique case (st)
         S_IDLE: if (direct_go) next_st = S_RDSYNC;
         S_RDSYNC: if (x.done) next_st = S_RDONE;
         S_RDONE: if (xfer_end) next_st = S_IDLE;
         default: next_st = S_IDLE;
      endcase
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         st <= S_IDLE;
         rd_hold <= 32'h0000_0000;
      end else begin
         st <= next_st;
         if (st == S_RDSYNC && x.done) begin
            rd_hold <= x.rdata;
         end
      end
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         cont_on <= 1'b0;
         rr_addr <= 8'h00;
      end else begin
         if ((access && wr_sync) || direct_go || rst_done) begin
            cont_on <= 1'b0;
         end
         if (xfer_end && PWRITE && rsel == R_CORE_READ_REQUEST_CONTROL) begin
            rr_addr <= PWDATA[7:0];
            if (PWDATA[RR_CONT]) begin
               cont_on <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         cap <= 32'h0000_0000;
         cap_valid <= 1'b0;
      end else if (rst_done) begin
         cap_valid <= 1'b0;
      end else if (x.done && op_q == OP_RD && st != S_RDSYNC) begin
         cap <= x.rdata;
         cap_valid <= 1'b1;
      end else if (xfer_end && PWRITE && rsel == R_CORE_READ_REQUEST_CONTROL &&
                   PWDATA[RR_TRIG]) begin
         cap_valid <= 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         en_sh <= 1'b0;
         soft_reset_trigger_bit <= 1'b0;
         corea_sh <= RST_COREA;
         buscfg <= RST_BUSCFG;
      end else if (rst_done) begin
         soft_reset_trigger_bit <= 1'b0;
         en_sh <= 1'b0;
         corea_sh <= RST_COREA;
         buscfg <= RST_BUSCFG;
      end else if (xfer_end && PWRITE) begin
         case (rsel)
            R_CTRL: begin
               if (PWDATA[CTRL_SOFT_RESET_TRIGGER]) begin
                  soft_reset_trigger_bit <= 1'b1;
               end else begin
                  en_sh <= PWDATA[CTRL_EN];
               end
            end
            R_COREA: corea_sh <= PWDATA;
            R_BUSCFG: buscfg <= PWDATA;
            default: ;
         endcase
      end
   end

   // completion flag, write one to clear; the setting event wins
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         sync_rdy <= 1'b0;
      end else if (x.done && pend && kind != K_CTL) begin
         sync_rdy <= 1'b1;
      end else if (xfer_end && PWRITE && rsel == R_STATUS &&
                   PWDATA[ST_RDY]) begin
         sync_rdy <= 1'b0;
      end
   end

   sequence s_core_wr_end;
      xfer_end && PWRITE && rsel == R_COREA;
   endsequence
   sequence s_status_rd;
      PSEL && !PENABLE && !PWRITE && rsel == R_STATUS ##1 access;
   endsequence

   property p_one_xfer;
      @(posedge MCLK) disable iff (!NRST) x.start |-> !x.busy ##1 x.busy;
   endproperty
   a_one_xfer: assert property (p_one_xfer)
      else $error("transfer started while engine busy");
   property p_pend_wr;
      @(posedge MCLK) disable iff (!NRST) s_core_wr_end |=> pend && x.start;
   endproperty
   a_pend_wr: assert property (p_pend_wr)
      else $error("core write did not raise pending");
   property p_stall_wr;
      @(posedge MCLK) disable iff (!NRST)
         access && wr_sync && eng_busy |-> !PREADY;
   endproperty
   a_stall_wr: assert property (p_stall_wr)
      else $error("core write not stalled while busy");
   property p_free_rd;
      @(posedge MCLK) disable iff (!NRST) s_status_rd |-> PREADY;
   endproperty
   a_free_rd: assert property (p_free_rd)
      else $error("status read was stalled");
   property p_rd_nopend;
      @(posedge MCLK) disable iff (!NRST) direct_go |=> !pend [*3];
   endproperty
   a_rd_nopend: assert property (p_rd_nopend)
      else $error("direct read raised pending");
   property p_cont_quiet;
      @(posedge MCLK) disable iff (!NRST) cont_go |=> !pend;
   endproperty
   a_cont_quiet: assert property (p_cont_quiet)
      else $error("repeated read raised pending");
   property p_en_rb;
      @(posedge MCLK) disable iff (!NRST)
         xfer_end && PWRITE && rsel == R_CTRL && !PWDATA[CTRL_SOFT_RESET_TRIGGER]
         |=> en_sh == $past(PWDATA[CTRL_EN]) && pend;
   endproperty
   a_en_rb: assert property (p_en_rb)
      else $error("enable bit did not read back");
   property p_ctl_stall;
      @(posedge MCLK) disable iff (!NRST)
         access && PWRITE && ctl_pend |-> !PREADY;
   endproperty
   a_ctl_stall: assert property (p_ctl_stall)
      else $error("write not stalled during enable sync");
   property p_no_rdy;
      @(posedge MCLK) disable iff (!NRST)
         x.done && kind == K_CTL |=> !$rose(sync_rdy);
   endproperty
   a_no_rdy: assert property (p_no_rdy)
      else $error("ready flag set by enable sync");
   property p_soft_reset_trigger;
      @(posedge MCLK) disable iff (!NRST)
         xfer_end && PWRITE && rsel == R_CTRL && PWDATA[CTRL_SOFT_RESET_TRIGGER]
         |=> soft_reset_trigger_bit && pend;
   endproperty
   a_soft_reset_trigger: assert property (p_soft_reset_trigger)
      else $error("soft reset trigger not set");
endmodule : crs_top
`default_nettype wire

// ---- common/crs_pkg.sv ----
// shared constants and types of the common register synchronizer
// assumes a 32-bit APB slave with byte addresses on an 8-bit bus
package crs_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // byte offsets of the register words
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_CORE_READ_REQUEST_CONTROL = 8'h08;
   localparam logic [7:0] OFF_BUSCFG = 8'h0C;
   localparam logic [7:0] OFF_COREA = 8'h10;
   localparam logic [7:0] OFF_COUNT = 8'h14;
   // field positions
   localparam int CTRL_SOFT_RESET_TRIGGER = 0;
   localparam int CTRL_EN = 1;
   localparam int ST_PEND = 0;
   localparam int ST_RDY = 1;
   localparam int ST_CONT = 2;
   localparam int RR_TRIG = 15;
   localparam int RR_CONT = 14;
   // reset values
   localparam logic [31:0] RST_BUSCFG = 32'h0000_0000;
   localparam logic [31:0] RST_COREA = 32'h0000_0000;
   // core clock edges one transfer waits for
   localparam int SYNC_TICKS = 6;

   typedef enum logic [1:0] {
      OP_WR = 2'b00, OP_EN = 2'b01, OP_RST = 2'b11, OP_RD = 2'b10
   } crs_op_t;
   typedef enum logic [1:0] {K_WR = 2'b00, K_CTL = 2'b01, K_RD = 2'b10} crs_kind_t;
   typedef enum logic [1:0] {
      S_IDLE = 2'b00, S_RDSYNC = 2'b01, S_RDONE = 2'b11
   } crs_state_t;
   typedef enum logic [2:0] {
      R_CTRL, R_STATUS, R_CORE_READ_REQUEST_CONTROL, R_BUSCFG, R_COREA, R_COUNT, R_NONE
   } crs_reg_t;

   function automatic crs_reg_t crs_decode(input logic [7:0] a);
      case (a)
         OFF_CTRL: crs_decode = R_CTRL;
         OFF_STATUS: crs_decode = R_STATUS;
         OFF_CORE_READ_REQUEST_CONTROL: crs_decode = R_CORE_READ_REQUEST_CONTROL;
         OFF_BUSCFG: crs_decode = R_BUSCFG;
         OFF_COREA: crs_decode = R_COREA;
         OFF_COUNT: crs_decode = R_COUNT;
         default: crs_decode = R_NONE;
      endcase
   endfunction : crs_decode
endpackage : crs_pkg

// ---- common/crs_xfer_if.sv ----
// transfer channel between bus side and the shared sync engine
// assumes both ends run on the bus clock
`timescale 1ns/1ps
`default_nettype none
interface crs_xfer_if;
   import crs_pkg::*;
   logic tick;
   logic start;
   crs_op_t op;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic busy;
   logic done;
   logic [31:0] rdata;
   modport ctl (output tick, start, op, addr, wdata,
                input busy, done, rdata);
   modport eng (input tick, start, op, addr, wdata,
                output busy, done, rdata);
endinterface : crs_xfer_if
`default_nettype wire

// ---- rtl/crs_sync_engine.sv ----
// shared sync engine holding the core-domain registers
// assumes tick marks one core clock rising edge, seen on the bus clock
`timescale 1ns/1ps
`default_nettype none
module crs_sync_engine
   import crs_pkg::*;
#(
   parameter int TICKS = SYNC_TICKS
) (
   input wire logic clk,
   input wire logic rst_n,
   crs_xfer_if.eng x
);
   localparam int TW = $clog2(TICKS + 1);
   if (TICKS < 1) begin : g_bad_ticks
      $error("TICKS must be at least 1");
   end

   logic [TW-1:0] ticks;
   crs_op_t op_q;
   logic [7:0] addr_q;
   logic [31:0] wdata_q;
   logic [31:0] core_a;
   logic core_en;
   logic [31:0] core_cnt;
   logic last;
   logic [1:0] tail;
   logic fin;

   // no core clock, no ticks: a stopped core clock simply parks the engine
   assign last = x.busy && x.tick && (ticks == TW'(TICKS - 1));
   // the acknowledge crosses back in two bus cycles; this keeps the stall
   // above its lower bound even when a core edge follows the start at once
   assign fin = tail[1];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tail <= 2'b00;
      end else begin
         tail <= {tail[0], last};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         x.busy <= 1'b0;
         ticks <= '0;
         op_q <= OP_WR;
         addr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
      end else if (x.start) begin
         x.busy <= 1'b1;
         ticks <= '0;
         op_q <= x.op;
         addr_q <= x.addr;
         wdata_q <= x.wdata;
      end else if (x.busy) begin
         if (x.tick && ticks != TW'(TICKS)) begin
            ticks <= ticks + 1'b1;
         end
         if (fin) begin
            x.busy <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         x.done <= 1'b0;
      end else begin
         x.done <= fin;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_a <= RST_COREA;
         core_en <= 1'b0;
         x.rdata <= 32'h0000_0000;
      end else if (last) begin
         unique case (op_q)
            OP_WR: core_a <= wdata_q;
            OP_EN: core_en <= wdata_q[CTRL_EN];
            OP_RST: begin
               core_a <= RST_COREA;
               core_en <= 1'b0;
            end
            OP_RD: begin
               case (addr_q)
                  OFF_COUNT: x.rdata <= core_cnt;
                  OFF_COREA: x.rdata <= core_a;
                  OFF_CTRL: x.rdata <= {30'h0000_0000, core_en, 1'b0};
                  default: x.rdata <= 32'h0000_0000;
               endcase
            end
         endcase
      end
   end

   // core counter, counting ticks only while enabled; the read-synchronized value
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_cnt <= 32'h0000_0000;
      end else if (last && op_q == OP_RST) begin
         core_cnt <= 32'h0000_0000;
      end else if (x.tick && core_en) begin
         core_cnt <= core_cnt + 32'h0000_0001;
      end
   end
endmodule : crs_sync_engine
`default_nettype wire

// ---- bench/crs_core_clk_model.sv ----
// core clock source facing the synchronizer's core side
// assumes the bench lowers run to model a sleep that stops the clock
`timescale 1ns/1ps
`default_nettype none
module crs_core_clk_model #(
   parameter real HALF_NS = 62.5
) (
   input wire logic run,
   output logic core_clk
);
   // a stopped clock parks low, so no stray edge reaches the sampler
   initial begin
      core_clk = 1'b0;
      forever begin
         #(HALF_NS);
         core_clk = run ? ~core_clk : 1'b0;
      end
   end
endmodule : crs_core_clk_model
`default_nettype wire

// ---- bench/test_crs_top.sv ----
// self-checking bench for the common register synchronizer
// assumes crs_top as APB slave on MCLK and the core clock model beside it
`timescale 1ns/1ps
`default_nettype none
module test_crs_top;
   import crs_pkg::*;
   localparam int PC = 125;
   localparam int PA = 4;
   localparam int LO1 = (5 * PC + 2 * PA) / PA + 1;
   localparam int HI1 = (6 * PC + 3 * PA - 1) / PA;
   localparam int LO2 = 2 * 5 * PC / PA;
   localparam int HI2 = 2 * HI1;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   logic MCLK, NRST, PSEL, PENABLE, PWRITE, core_run, core_clk;
   logic [7:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rd, v;
   logic PREADY, PSLVERR, DOMAIN_TRANSFER_PENDING, er;
   int fails, cmp_count, ws, pend_cnt;

   crs_top crs_top_inst (.MCLK(MCLK), .NRST(NRST),
      .CORE_CLOCK_GENERATOR(core_clk), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR),
      .DOMAIN_TRANSFER_PENDING(DOMAIN_TRANSFER_PENDING));
   crs_core_clk_model crs_core_clk_model_inst (.run(core_run),
      .core_clk(core_clk));

   initial begin
      MCLK = 1'b0;
      forever #2 MCLK = ~MCLK;
   end

   always @(posedge MCLK) begin
      if (DOMAIN_TRANSFER_PENDING === 1'b1) pend_cnt++;
   end

   task automatic test_done;
      $display("counts: %0d compared, %0d mismatched", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : test_done

   // one APB transfer; the request holds until PREADY is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge MCLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      ws = 0;
      @(posedge MCLK);
      while (PREADY !== 1'b1 && ws < 2000) begin
         ws++;
         @(posedge MCLK);
      end
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (ws >= 2000) begin
         fails++;
         $display("BAD %0t: access never completed", $time);
         test_done();
      end
   endtask : apb

   task automatic chk_val(input logic [31:0] got, exp, mask);
      cmp_count++;
      if ((got & mask) !== (exp & mask)) begin
         fails++;
         $display("BAD %0t: value %h, expected %h", $time, got, exp);
      end
   endtask : chk_val

   task automatic chk_wait(input int got, lo, hi);
      cmp_count++;
      if (got < lo || got > hi) begin
         fails++;
         $display("BAD %0t: %0d wait states, want %0d..%0d", $time, got,
                  lo, hi);
      end
   endtask : chk_wait

   // poll the status word until the pending flag drops
   task automatic wait_idle;
      int n;
      n = 0;
      rd = 32'h0000_0001;
      while (rd[ST_PEND] !== 1'b0 && n < 200) begin
         apb(1'b0, OFF_STATUS, 32'h0000_0000);
         n++;
      end
      chk_val(rd, 32'h0000_0000, 32'h0000_0001);
   endtask : wait_idle

   initial begin
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = 8'h00;
      PWDATA = 32'h0000_0000;
      NRST = 1'b0;
      core_run = 1'b1;
      fails = 0;
      cmp_count = 0;
      pend_cnt = 0;
      repeat (10) @(posedge MCLK);
      NRST <= 1'b1;
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      chk_val(rd, 32'h0000_0000, ALL);
      apb(1'b1, OFF_BUSCFG, 32'hA5A5_0F0F);
      chk_wait(ws, 0, 0);
      apb(1'b0, OFF_BUSCFG, 32'h0000_0000);
      chk_val(rd, 32'hA5A5_0F0F, ALL);
      chk_wait(ws, 0, 0);
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk_val({rd[30:0], er}, 32'h0000_0001, ALL);
      $display("test plain access done");

      apb(1'b1, OFF_COREA, 32'h1234_5678);
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      chk_val(rd, 32'h0000_0001, 32'h0000_0001);
      chk_wait(ws, 0, 0);
      apb(1'b0, OFF_BUSCFG, 32'h0000_0000);
      chk_wait(ws, 0, 0);
      apb(1'b0, OFF_COREA, 32'h0000_0000);
      chk_val(rd, 32'h1234_5678, ALL);
      chk_wait(ws, 1, HI1);
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      chk_val(rd, 32'h0000_0002, 32'h0000_0003);
      apb(1'b1, OFF_COREA, 32'h0000_00C3);
      apb(1'b1, OFF_COREA, 32'h0000_003C);
      chk_wait(ws, 1, HI1);
      wait_idle();
      $display("test write sync done");

      pend_cnt = 0;
      apb(1'b0, OFF_COUNT, 32'h0000_0000);
      chk_wait(ws, LO1, HI1);
      chk_val(rd, 32'h0000_0000, ALL);
      chk_val(32'(pend_cnt), 32'h0000_0000, ALL);
      apb(1'b1, OFF_COREA, 32'h0000_0011);
      apb(1'b0, OFF_COUNT, 32'h0000_0000);
      chk_wait(ws, LO2, HI2);
      $display("test direct read done");

      apb(1'b1, OFF_STATUS, 32'h0000_0002);
      apb(1'b1, OFF_CTRL, 32'h0000_0002);
      apb(1'b0, OFF_CTRL, 32'h0000_0000);
      chk_val(rd, 32'h0000_0002, 32'h0000_0002);
      chk_wait(ws, 0, 0);
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      chk_val(rd, 32'h0000_0001, 32'h0000_0001);
      apb(1'b1, OFF_BUSCFG, 32'h0000_0077);
      chk_wait(ws, 1, HI1);
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      chk_val(rd, 32'h0000_0000, 32'h0000_0003);
      $display("test enable sync done");

      apb(1'b1, OFF_CORE_READ_REQUEST_CONTROL, 32'h0000_8014);
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      chk_val(rd, 32'h0000_0001, 32'h0000_0001);
      wait_idle();
      apb(1'b0, OFF_COUNT, 32'h0000_0000);
      chk_wait(ws, 0, 0);
      v = rd;
      repeat (200) @(posedge MCLK);
      apb(1'b0, OFF_COUNT, 32'h0000_0000);
      chk_val(rd, v, ALL);
      chk_wait(ws, 0, 0);
      $display("test single read done");

      apb(1'b1, OFF_CORE_READ_REQUEST_CONTROL, 32'h0000_4014);
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      chk_val(rd, 32'h0000_0001, 32'h0000_0001);
      wait_idle();
      pend_cnt = 0;
      repeat (400) @(posedge MCLK);
      chk_val(32'(pend_cnt), 32'h0000_0000, ALL);
      apb(1'b0, OFF_COUNT, 32'h0000_0000);
      chk_wait(ws, 0, 0);
      v = rd;
      repeat (400) @(posedge MCLK);
      apb(1'b0, OFF_COUNT, 32'h0000_0000);
      chk_wait(ws, 0, 0);
      chk_val({31'h0, rd > v}, 32'h0000_0001, ALL);
      core_run <= 1'b0;
      repeat (300) @(posedge MCLK);
      pend_cnt = 0;
      apb(1'b0, OFF_COUNT, 32'h0000_0000);
      v = rd;
      repeat (300) @(posedge MCLK);
      apb(1'b0, OFF_COUNT, 32'h0000_0000);
      chk_val(rd, v, ALL);
      chk_wait(ws, 0, 0);
      chk_val(32'(pend_cnt), 32'h0000_0000, ALL);
      core_run <= 1'b1;
      repeat (400) @(posedge MCLK);
      apb(1'b0, OFF_COUNT, 32'h0000_0000);
      chk_val({31'h0, rd > v}, 32'h0000_0001, ALL);
      apb(1'b1, OFF_COREA, 32'h0000_0005);
      wait_idle();
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      chk_val(rd, 32'h0000_0000, 32'h0000_0004);
      apb(1'b0, OFF_CORE_READ_REQUEST_CONTROL, 32'h0000_0000);
      chk_val(rd, 32'h0000_0014, 32'h0000_40FF);
      $display("test continuous read done");

      apb(1'b1, OFF_STATUS, 32'h0000_0002);
      apb(1'b1, OFF_CTRL, 32'h0000_0001);
      apb(1'b0, OFF_CTRL, 32'h0000_0000);
      chk_val(rd, 32'h0000_0001, 32'h0000_0001);
      chk_wait(ws, 0, 0);
      wait_idle();
      apb(1'b0, OFF_CTRL, 32'h0000_0000);
      chk_val(rd, 32'h0000_0000, 32'h0000_0001);
      apb(1'b0, OFF_BUSCFG, 32'h0000_0000);
      chk_val(rd, RST_BUSCFG, ALL);
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      chk_val(rd, 32'h0000_0000, 32'h0000_0002);
      $display("test soft reset done");
      test_done();
   end
endmodule : test_crs_top
`default_nettype wire
